// ---- pkg/gmcd_pkg.sv ----
/*
 Shared constants and types for the monitor-channel command decoder.
 Assumes a byte-level monitor transport outside: bytes already de-duplicated and acknowledged.
*/
package gmcd_pkg;
    localparam int NUM_CH     = 4;
    localparam int NUM_REGS   = 8;
    localparam int COEF_SETS  = 9;
    localparam int COEF_BYTES = 14;
    localparam int FSC_WAIT   = 2;

    // Address byte layout
    localparam logic [7:0] ADDR_FIX_MASK = 8'hE6;
    localparam logic [7:0] ADDR_FIX_VAL  = 8'h80;
    localparam int         ADDR_CH_BIT   = 4;
    localparam int         ADDR_BOTH_BIT = 3;
    localparam int         ADDR_OP_BIT   = 0;

    localparam logic [7:0] CMD_CIC       = 8'h00;
    localparam logic [7:0] CMD_REV_RD    = 8'h73;
    localparam logic [7:0] CMD_DEACT     = 8'h00;
    localparam logic [7:0] CMD_SW_RESET  = 8'h02;
    localparam logic [7:0] CMD_HW_RESET  = 8'h04;
    localparam logic [7:0] CMD_ACT       = 8'h0E;
    localparam logic [7:0] CMD_SLICIO_RD = 8'h53;
    localparam logic [7:0] CMD_RTDATA_A  = 8'h4D;
    localparam logic [7:0] CMD_RTDATA_B  = 8'h4F;
    localparam logic [7:0] CID_HEAD      = 8'h80;
    localparam logic [7:0] CID_TYPE_BYTE = 8'h86;

    // Register indices and their write codes (read code = write code + 1)
    localparam logic [3:0] REG_OPCOND = 4'h0;
    localparam logic [3:0] REG_CHIPCF = 4'h1;
    localparam logic [3:0] REG_OPFUNC = 4'h2;
    localparam logic [3:0] REG_PINDIR = 4'h3;
    localparam logic [3:0] REG_OPMODE = 4'h4;
    localparam logic [3:0] REG_DEBNC  = 4'h5;
    localparam logic [3:0] REG_GKINT  = 4'h6;
    localparam logic [3:0] REG_INTMSK = 4'h7;
    localparam logic [3:0] RD_SLICIO  = 4'h8;
    localparam logic [3:0] RD_RTDATA  = 4'h9;
    localparam logic [7:0][7:0] REG_WR_CODES = {8'h6C, 8'hE8, 8'hC8, 8'h4A,
                                                8'h54, 8'h60, 8'h46, 8'h70};
    localparam logic [7:0] REG_GLOBAL_MASK = 8'h12;
    localparam logic [7:0] PINDIR_WR_MASK  = 8'h1F;
    localparam logic [8:0][7:0] COEF_WR_CODES = {8'h9A, 8'h96, 8'h8A, 8'h88,
                                                 8'h86, 8'h98, 8'h82, 8'h80, 8'h50};

    localparam logic [7:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h0F,
                                             8'h00, 8'h00, 8'h00, 8'h00};

    typedef logic [NUM_REGS-1:0][7:0] gmcd_chan_regs_type;

    typedef enum logic [2:0] {
        ST_ADDR, ST_CMD, ST_WRITE, ST_REPLY, ST_SKIP
    } gmcd_state_type;

    typedef enum logic [3:0] {
        K_NONE, K_CIC, K_REV, K_DEACT, K_SWRST, K_HWRST, K_ACT,
        K_REG_WR, K_REG_RD, K_COEF_WR, K_COEF_RD
    } gmcd_kind_type;

    typedef struct packed {
        gmcd_kind_type kind;
        logic [3:0]    idx;
    } gmcd_dec_type;

    typedef struct packed {
        gmcd_state_type                   state;
        logic [7:0]                       addr;
        gmcd_kind_type                    kind;
        logic [3:0]                       idx;
        logic [3:0]                       cnt;
        logic [3:0]                       len;
        logic [7:0]                       tx_data;
        logic                             tx_eom;
        logic [NUM_CH-1:0]                active;
        logic [NUM_CH-1:0]                b_en;
        logic [NUM_CH-1:0]                fsc_cnt;
        gmcd_chan_regs_type [NUM_CH-1:0]  regs;
        logic [NUM_CH-1:0][COEF_SETS-1:0][COEF_BYTES-1:0][7:0] coef;
    } gmcd_st_type;
endpackage

// ---- design/gmcd_decoder.sv ----
/*
 Monitor-channel command decoder for a four-channel voice codec.
 Assumes bytes arrive one per RX_VALID pulse, already accepted by the
 monitor handshake, and that RX_EOM pulses when the downstream end of
 message is seen. Replies leave on TX_DATA under TX_VALID/TX_READY.
*/
// Function
// - Command 00h after 80h/90h is identification
// - 73h returns one revision byte
// - Transfer read changes nothing, at most fourteen
// - Status write five bits, read eight
// - Deactivate keeps all programmed values
// - Standby keeps monitor and signalling alive
// - Standby channel B timeslot stays idle
// - Standby disables analog output at bias
// - Deactivate clears channel active flag
// - Software reset addressed channels, keep ground-key
// - Hardware reset command resets all channels
// - 0Eh activates the addressed channel
// - No B data before second frame sync
// - Activate sets channel active flag
// - Decode 70/71, 46/47, 60/61 registers
// - Decode 4A/4B mode, 53h pin read
// - Decode C8/C9 debounce, E8/E9 ground-key
// - Decode 4D/4F realtime, 6C/6D mask
// - Decode 50/51, 80/81, 82/83 coefficients
// - Decode 98/99, 86/87, 88/89 coefficients
// - Decode 8A/8B, 96/97, 9A/9B coefficients
// - Operations only after 81h/89h/91h/99h address
// - Send end of message, await downstream one
`timescale 1ns/1ns
module gmcd_decoder #(
    parameter logic [7:0] REVISION = 8'h01  // Arbitrary value
) (
    input  wire logic                                   CLK,
    input  wire logic                                   RESET_N,
    input  wire logic                                   FRAME_SYNC_PULSE,
    input  wire logic                                   GCI_PAIR_SEL,
    input  wire logic                                   RX_VALID,
    input  wire logic [7:0]                             RX_DATA,
    input  wire logic                                   RX_EOM,
    output logic                                        TX_VALID,
    output logic      [7:0]                             TX_DATA,
    input  wire logic                                   TX_READY,
    output logic                                        TX_EOM,
    input  wire logic [gmcd_pkg::NUM_CH-1:0][7:0]       SLIC_IO_IN,
    input  wire logic [gmcd_pkg::NUM_CH-1:0][7:0]       REALTIME_IN,
    input  wire logic                                   CLOCK_FAIL,
    output logic      [gmcd_pkg::NUM_CH-1:0]            CHANNEL_ACTIVE_FLAG,
    output logic      [gmcd_pkg::NUM_CH-1:0]            B_CHANNEL_ENABLE,
    output logic      [gmcd_pkg::NUM_CH-1:0]            ANALOG_OUTPUT_DISABLE,
    output gmcd_pkg::gmcd_chan_regs_type [gmcd_pkg::NUM_CH-1:0] CHAN_REGS
);
    import gmcd_pkg::*;

    gmcd_st_type s_reg;
    gmcd_st_type s_next;
    gmcd_dec_type dec;

    function automatic gmcd_st_type reset_state();
        gmcd_st_type r;
        r = '0;
        r.state = ST_ADDR;
        r.kind = K_NONE;
        for (int c = 0; c < NUM_CH; c++) begin
            r.regs[c] = REG_RESET;
        end
        return r;
    endfunction

    function automatic gmcd_dec_type decode(input logic [7:0] b);
        gmcd_dec_type d;
        d.kind = K_NONE;
        d.idx = 4'h0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (b[7:1] == REG_WR_CODES[i][7:1]) begin
                d.kind = b[0] ? K_REG_RD : K_REG_WR;
                d.idx = 4'(i);
            end
        end
        for (int i = 0; i < COEF_SETS; i++) begin
            if (b[7:1] == COEF_WR_CODES[i][7:1]) begin
                d.kind = b[0] ? K_COEF_RD : K_COEF_WR;
                d.idx = 4'(i);
            end
        end
        if (b == CMD_SLICIO_RD) begin
            d.kind = K_REG_RD;
            d.idx = RD_SLICIO;
        end
        if (b == CMD_RTDATA_A || b == CMD_RTDATA_B) begin
            d.kind = K_REG_RD;
            d.idx = RD_RTDATA;
        end
        if (b == CMD_REV_RD) begin
            d.kind = K_REV;
        end
        if (b == CMD_DEACT) begin
            d.kind = K_DEACT;
        end
        if (b == CMD_SW_RESET) begin
            d.kind = K_SWRST;
        end
        if (b == CMD_HW_RESET) begin
            d.kind = K_HWRST;
        end
        if (b == CMD_ACT) begin
            d.kind = K_ACT;
        end
        return d;
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic op);
        return ((a & ADDR_FIX_MASK) == ADDR_FIX_VAL) && (a[ADDR_OP_BIT] == op);
    endfunction

    // Channels hit by a write or mode command
    function automatic logic [NUM_CH-1:0] chan_mask(input logic [7:0] a);
        logic [1:0] pair;
        pair = a[ADDR_BOTH_BIT] ? 2'b11 : (a[ADDR_CH_BIT] ? 2'b10 : 2'b01);
        return GCI_PAIR_SEL ? {pair, 2'b00} : {2'b00, pair};
    endfunction

    function automatic logic [1:0] read_ch(input logic [7:0] a);
        return {GCI_PAIR_SEL, a[ADDR_CH_BIT]};
    endfunction

    function automatic logic [7:0] reply_byte(input gmcd_st_type st, input gmcd_kind_type k,
                                              input logic [3:0] idx, input logic [3:0] n);
        logic [1:0] ch;
        logic [7:0] v;
        ch = read_ch(st.addr);
        v = 8'h00;
        unique case (k)
            K_CIC:     v = (n == 4'h0) ? (CID_HEAD | {3'b000, st.addr[ADDR_CH_BIT], 4'h0})
                                       : CID_TYPE_BYTE;
            K_REV:     v = REVISION;
            K_COEF_RD: v = st.coef[ch][idx][n];
            K_REG_RD: begin
                if (idx == RD_SLICIO) begin
                    v = SLIC_IO_IN[ch];
                end else if (idx == RD_RTDATA) begin
                    v = REALTIME_IN[ch];
                end else if (idx == REG_PINDIR) begin
                    v = {1'b0, st.active[ch], CLOCK_FAIL,
                         st.regs[ch][REG_PINDIR][4:0]};
                end else begin
                    v = st.regs[ch][idx[2:0]];
                end
            end
            K_NONE, K_DEACT, K_SWRST, K_HWRST, K_ACT, K_REG_WR, K_COEF_WR: v = 8'h00;
        endcase
        return v;
    endfunction

    assign dec = decode(RX_DATA);

    always_comb begin
        logic [NUM_CH-1:0] m;
        m = chan_mask(s_reg.addr);
        s_next = s_reg;
        s_next.tx_eom = 1'b0;
        // Frame sync gating of the B channel after activation
        for (int c = 0; c < NUM_CH; c++) begin
            if (FRAME_SYNC_PULSE && s_reg.active[c] && !s_reg.b_en[c]) begin
                if (s_reg.fsc_cnt[c] == 1'(FSC_WAIT - 1)) begin
                    s_next.b_en[c] = 1'b1;
                end else begin
                    s_next.fsc_cnt[c] = 1'b1;
                end
            end
        end
        unique case (s_reg.state)
            ST_ADDR: begin
                if (RX_VALID) begin
                    s_next.addr = RX_DATA;
                    s_next.state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (RX_VALID) begin
                    s_next.kind = dec.kind;
                    s_next.idx = dec.idx;
                    s_next.cnt = 4'h0;
                    s_next.state = ST_SKIP;
                    if (is_addr(s_reg.addr, 1'b0)) begin
                        if (!s_reg.addr[ADDR_BOTH_BIT] && RX_DATA == CMD_CIC) begin
                            s_next.kind = K_CIC;
                            s_next.len = 4'd2;
                            s_next.tx_data = reply_byte(s_reg, K_CIC, 4'h0, 4'h0);
                            s_next.state = ST_REPLY;
                        end
                    end else if (is_addr(s_reg.addr, 1'b1)) begin
                        unique case (dec.kind)
                            K_DEACT: begin
                                // Registers and coefficients untouched
                                for (int c = 0; c < NUM_CH; c++) begin
                                    if (m[c]) begin
                                        s_next.active[c] = 1'b0;
                                        s_next.b_en[c] = 1'b0;
                                    end
                                end
                            end
                            K_ACT: begin
                                for (int c = 0; c < NUM_CH; c++) begin
                                    if (m[c] && !s_reg.active[c]) begin
                                        s_next.active[c] = 1'b1;
                                        s_next.fsc_cnt[c] = 1'b0;
                                    end
                                end
                            end
                            K_SWRST: begin
                                for (int c = 0; c < NUM_CH; c++) begin
                                    if (m[c]) begin
                                        s_next.regs[c] = REG_RESET;
                                        s_next.regs[c][REG_GKINT] = s_reg.regs[c][REG_GKINT];
                                        s_next.coef[c] = '0;
                                        s_next.active[c] = 1'b0;
                                        s_next.b_en[c] = 1'b0;
                                    end
                                end
                            end
                            K_HWRST: begin
                                s_next = reset_state();
                                s_next.state = ST_SKIP;
                            end
                            K_REV, K_REG_RD, K_COEF_RD: begin
                                // Reads load the first byte only; no state changes
                                s_next.len = (dec.kind == K_COEF_RD) ? 4'(COEF_BYTES) : 4'd1;
                                s_next.tx_data = reply_byte(s_reg, dec.kind, dec.idx, 4'h0);
                                s_next.state = ST_REPLY;
                            end
                            K_REG_WR, K_COEF_WR: s_next.state = ST_WRITE;
                            K_NONE, K_CIC: s_next.state = ST_SKIP;
                        endcase
                    end
                end
            end
            ST_WRITE: begin
                if (RX_VALID) begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        // Globals go to every channel copy so any channel reads them back
                        if (m[c] || (s_reg.kind == K_REG_WR
                                     && REG_GLOBAL_MASK[s_reg.idx[2:0]])) begin
                            if (s_reg.kind == K_REG_WR && s_reg.cnt == 4'h0) begin
                                s_next.regs[c][s_reg.idx[2:0]] = (s_reg.idx == REG_PINDIR)
                                    ? (RX_DATA & PINDIR_WR_MASK) : RX_DATA;
                            end
                            if (s_reg.kind == K_COEF_WR && s_reg.cnt < 4'(COEF_BYTES)) begin
                                s_next.coef[c][s_reg.idx][s_reg.cnt] = RX_DATA;
                            end
                        end
                    end
                    if (s_reg.cnt != 4'hF) begin
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end
                end
            end
            ST_REPLY: begin
                if (TX_READY) begin
                    if (s_reg.cnt == s_reg.len - 4'h1) begin
                        s_next.tx_eom = 1'b1;
                        s_next.state = ST_SKIP;
                    end else begin
                        s_next.cnt = s_reg.cnt + 4'h1;
                        s_next.tx_data = reply_byte(s_reg, s_reg.kind, s_reg.idx,
                                                    s_reg.cnt + 4'h1);
                    end
                end
            end
            ST_SKIP: ;
        endcase
        // A new message starts only after the downstream end of message
        if (RX_EOM && s_reg.state != ST_REPLY) begin
            s_next.state = ST_ADDR;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg <= reset_state();
        end else begin
            s_reg <= s_next;
        end
    end

    // Monitor and signalling service does not depend on channel state
    assign TX_VALID = (s_reg.state == ST_REPLY);
    assign TX_DATA = s_reg.tx_data;
    assign TX_EOM = s_reg.tx_eom;
    assign CHANNEL_ACTIVE_FLAG = s_reg.active;
    assign B_CHANNEL_ENABLE = s_reg.b_en & s_reg.active;
    assign ANALOG_OUTPUT_DISABLE = ~s_reg.active;
    assign CHAN_REGS = s_reg.regs;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_rev_byte: assert property (TX_VALID && s_reg.kind == K_REV |-> TX_DATA == REVISION)
        else $error("revision byte wrong");
    a_reply_len: assert property (TX_VALID |-> s_reg.cnt < 4'(COEF_BYTES))
        else $error("reply longer than fourteen bytes");
    a_read_stable: assert property (TX_VALID |=> $stable(s_reg.regs) && $stable(s_reg.active))
        else $error("read changed state");
    a_cic_id: assert property (TX_VALID && s_reg.kind == K_CIC && s_reg.cnt == 4'h1
                               |-> TX_DATA == CID_TYPE_BYTE)
        else $error("identification byte wrong");
    a_deact_clear: assert property (s_reg.state == ST_CMD && RX_VALID && !RX_EOM
                                    && is_addr(s_reg.addr, 1'b1) && RX_DATA == CMD_DEACT
                                    |=> (CHANNEL_ACTIVE_FLAG & chan_mask(s_reg.addr)) == '0
                                        && $stable(s_reg.regs))
        else $error("deactivate did not clear flag");
    a_act_set: assert property (s_reg.state == ST_CMD && RX_VALID && !RX_EOM
                                && is_addr(s_reg.addr, 1'b1) && RX_DATA == CMD_ACT
                                |=> (CHANNEL_ACTIVE_FLAG & chan_mask($past(s_reg.addr)))
                                    == chan_mask($past(s_reg.addr)))
        else $error("activate did not set flag");
    a_bch_wait: assert property ($rose(B_CHANNEL_ENABLE[0]) |-> $past(FRAME_SYNC_PULSE)
                                 && $past(s_reg.fsc_cnt[0]))
        else $error("B channel enabled too early");
    // The output gate hides a stale enable, so check the enable register itself
    a_standby_idle: assert property ((s_reg.b_en & ~s_reg.active) == '0)
        else $error("B channel live in standby");
    a_hw_reset: assert property (s_reg.state == ST_CMD && RX_VALID && !RX_EOM
                                 && is_addr(s_reg.addr, 1'b1) && RX_DATA == CMD_HW_RESET
                                 |=> CHANNEL_ACTIVE_FLAG == '0 && s_reg.state == ST_SKIP)
        else $error("hardware reset incomplete");
    a_unknown_keep: assert property (s_reg.state == ST_CMD && RX_VALID && !RX_EOM
                                     && is_addr(s_reg.addr, 1'b1) && dec.kind == K_NONE
                                     |=> $stable(s_reg.regs) && $stable(s_reg.active)
                                         && s_reg.state == ST_SKIP)
        else $error("unknown command changed state");
    a_swrst_gk: assert property (s_reg.state == ST_CMD && RX_VALID && !RX_EOM
                                 && is_addr(s_reg.addr, 1'b1) && RX_DATA == CMD_SW_RESET
                                 |=> $stable(CHAN_REGS[0][REG_GKINT])
                                     && $stable(CHAN_REGS[1][REG_GKINT])
                                     && $stable(CHAN_REGS[2][REG_GKINT])
                                     && $stable(CHAN_REGS[3][REG_GKINT]))
        else $error("software reset touched ground-key interval");
    a_eom_end: assert property (TX_EOM |-> !TX_VALID ##1 !TX_EOM)
        else $error("end of message malformed");

    c_cic: cover property (TX_EOM && s_reg.kind == K_CIC);
    c_coef_rd: cover property (TX_EOM && s_reg.kind == K_COEF_RD);
    c_b_enable: cover property ($rose(B_CHANNEL_ENABLE[0]));
    c_swrst: cover property (s_reg.state == ST_CMD && RX_VALID && RX_DATA == CMD_SW_RESET);
endmodule

// ---- verif/gmcd_ctrl_model.sv ----
/*
 Behavioural upstream line-card controller: sends monitor bytes, takes replies.
 Assumes the decoder samples on the rising edge; this model drives on the falling edge.
*/
`timescale 1ns/1ns
module gmcd_ctrl_model (
    input  wire logic       CLK,
    output logic            RX_VALID,
    output logic      [7:0] RX_DATA,
    output logic            RX_EOM,
    input  wire logic       TX_VALID,
    input  wire logic [7:0] TX_DATA,
    output logic            TX_READY,
    input  wire logic       TX_EOM
);
    int eom_count = 0;
    int lag       = 0;
    initial begin
        RX_VALID = 1'b0;
        RX_DATA  = 8'h00;
        RX_EOM   = 1'b0;
        TX_READY = 1'b0;
    end
    always @(posedge CLK) begin
        if (TX_EOM === 1'b1) begin
            eom_count <= eom_count + 1;
        end
    end
    task automatic put_byte(input logic [7:0] b);
        @(negedge CLK);
        RX_VALID = 1'b1;
        RX_DATA  = b;
        @(negedge CLK);
        RX_VALID = 1'b0;
        // Released line shows the inverse so a stale byte cannot pass
        RX_DATA  = ~b;
    endtask
    task automatic end_msg();
        @(negedge CLK);
        RX_EOM = 1'b1;
        @(negedge CLK);
        RX_EOM = 1'b0;
    endtask
    task automatic get_byte(output logic [7:0] b);
        int i;
        @(negedge CLK);
        repeat (lag) @(negedge CLK);
        for (i = 0; i < 200 && TX_VALID !== 1'b1; i++) @(negedge CLK);
        TX_READY = 1'b1;
        b        = TX_DATA;
        @(negedge CLK);
        TX_READY = 1'b0;
    endtask
endmodule

// ---- verif/gmcd_decoder_tb.sv ----
/*
 Self-checking bench for the monitor command decoder: message sequences with expectations.
 Assumes the decoder's own assertions run inside it; channel pair strap held at 0.
*/
`timescale 1ns/1ns
module gmcd_decoder_tb;
    import gmcd_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, fsp = 1'b0, clock_fail = 1'b0;
    logic rx_valid, rx_eom, tx_valid, tx_ready, tx_eom;
    logic [7:0] rx_data, tx_data;
    logic [NUM_CH-1:0][7:0] slic_io = {8'hA1, 8'hB2, 8'hC3, 8'hD4};
    logic [NUM_CH-1:0][7:0] rt_data = {8'h15, 8'h26, 8'h37, 8'h48};
    logic [NUM_CH-1:0] act, b_en, ao_dis;
    gmcd_chan_regs_type [NUM_CH-1:0] regs;
    logic [7:0] got [14];
    logic [7:0] wc [7] = '{8'h70, 8'h46, 8'h60, 8'h4A, 8'hC8, 8'hE8, 8'h6C};
    int         ix [7] = '{0, 1, 2, 4, 5, 6, 7};
    logic [7:0] cc [9] = '{8'h50, 8'h80, 8'h82, 8'h98, 8'h86, 8'h88, 8'h8A, 8'h96, 8'h9A};
    int err_total = 0, num_checks = 0, cycles = 0, exp_eom = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    gmcd_decoder u_gmcd_decoder (
        .CLK(clk), .RESET_N(reset_n), .FRAME_SYNC_PULSE(fsp), .GCI_PAIR_SEL(1'b0),
        .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_EOM(rx_eom), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .TX_READY(tx_ready), .TX_EOM(tx_eom), .SLIC_IO_IN(slic_io),
        .REALTIME_IN(rt_data), .CLOCK_FAIL(clock_fail), .CHANNEL_ACTIVE_FLAG(act),
        .B_CHANNEL_ENABLE(b_en), .ANALOG_OUTPUT_DISABLE(ao_dis), .CHAN_REGS(regs)
    );
    gmcd_ctrl_model u_gmcd_ctrl_model (
        .CLK(clk), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_EOM(rx_eom),
        .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .TX_EOM(tx_eom)
    );
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] a, input logic [7:0] c, input int n,
                        input logic [7:0] base);
        u_gmcd_ctrl_model.put_byte(a);
        u_gmcd_ctrl_model.put_byte(c);
        for (int k = 0; k < n; k++) u_gmcd_ctrl_model.put_byte(base + 8'(k));
        u_gmcd_ctrl_model.end_msg();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] c, input int n);
        u_gmcd_ctrl_model.put_byte(a);
        u_gmcd_ctrl_model.put_byte(c);
        for (int k = 0; k < n; k++) u_gmcd_ctrl_model.get_byte(got[k]);
        exp_eom++;
        u_gmcd_ctrl_model.end_msg();
        chk("reply end", 8'(exp_eom), 8'(u_gmcd_ctrl_model.eom_count));
    endtask
    task automatic frame();
        @(negedge clk);
        fsp = 1'b1;
        @(negedge clk);
        fsp = 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 1300 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        for (int c = 0; c < NUM_CH; c++)
            for (int r = 0; r < NUM_REGS; r++) chk("reset reg", REG_RESET[r], regs[c][r]);
        chk("reset flags", 8'h00, {4'h0, act});
        chk("reset disable", 8'h0F, {4'h0, ao_dis});
        rd(8'h80, 8'h00, 2);
        chk("cic byte1", 8'h80, got[0]);
        chk("cic byte2", 8'h86, got[1]);
        rd(8'h90, 8'h00, 2);
        chk("cic byte1 A", 8'h90, got[0]);
        rd(8'h81, 8'h73, 1);
        chk("revision", 8'h01, got[0]);
        for (int i = 0; i < 7; i++) begin
            send(8'h81, wc[i], (i == 0) ? 7 : 1, 8'h30 + 8'(i));
            chk("reg write", 8'h30 + 8'(i), regs[0][ix[i]]);
            rd(8'h81, wc[i] + 8'h01, 1);
            chk("reg read", 8'h30 + 8'(i), got[0]);
        end
        rd(8'h81, 8'h53, 1);
        chk("pin read", slic_io[0], got[0]);
        rd(8'h81, 8'h4D, 1);
        chk("realtime 4D", rt_data[0], got[0]);
        rd(8'h81, 8'h4F, 1);
        chk("realtime 4F", rt_data[0], got[0]);
        u_gmcd_ctrl_model.lag = 3;
        for (int i = 0; i < 9; i++) begin
            send(8'h81, cc[i], 14, 8'(i * 16));
            rd(8'h81, cc[i] + 8'h01, 14);
            for (int j = 0; j < 14; j++) chk("coef", 8'(i * 16 + j), got[j]);
        end
        u_gmcd_ctrl_model.lag = 0;
        send(8'h81, 8'h0E, 0, 8'h00);
        chk("active flag", 8'h01, {4'h0, act});
        chk("analog on", 8'h0E, {4'h0, ao_dis});
        chk("b slot early", 8'h00, {4'h0, b_en});
        frame();
        @(negedge clk);
        chk("b slot one fsc", 8'h00, {4'h0, b_en});
        frame();
        @(negedge clk);
        chk("b slot open", 8'h01, {4'h0, b_en});
        send(8'h81, 8'h54, 1, 8'hFF);
        rd(8'h81, 8'h55, 1);
        chk("status active", 8'h5F, got[0]);
        send(8'h81, 8'h00, 0, 8'h00);
        chk("deact flag", 8'h00, {4'h0, act});
        chk("deact b slot", 8'h00, {4'h0, b_en});
        chk("deact analog", 8'h0F, {4'h0, ao_dis});
        chk("deact keeps", 8'h30, regs[0][0]);
        rd(8'h81, 8'h71, 1);
        chk("standby read", 8'h30, got[0]);
        rd(8'h81, 8'h55, 1);
        chk("status standby", 8'h1F, got[0]);
        send(8'h91, 8'h70, 1, 8'h5A);
        send(8'h81, 8'h02, 0, 8'h00);
        chk("swrst reg", 8'h00, regs[0][0]);
        chk("swrst gk kept", 8'h35, regs[0][6]);
        chk("swrst other ch", 8'h5A, regs[1][0]);
        send(8'h91, 8'h5F, 1, 8'hC3);
        chk("unknown cmd", 8'h5A, regs[1][0]);
        send(8'h82, 8'h70, 1, 8'hC3);
        chk("bad address", 8'h00, regs[0][0]);
        send(8'h89, 8'h70, 1, 8'h66);
        chk("both ch0", 8'h66, regs[0][0]);
        chk("both ch1", 8'h66, regs[1][0]);
        send(8'h81, 8'h04, 0, 8'h00);
        chk("hwrst other ch", 8'h00, regs[1][0]);
        chk("hwrst gk", 8'h00, regs[0][6]);
        complete_run();
    end
endmodule
